// *** hps_top.sv ***
// host port select, address strobe and ready/acknowledge handshake
`timescale 1ns/1ns
`default_nettype none
`include "hps_defines.svh"

// Contract
// - shared pins act as host port only in processor control mode
// - first bus style: handshake pin is an active-low ready output
// - ready goes low only once access can complete; high until then
// - second bus style: same pin is an active-low transfer acknowledge
// - hardware mode: chip select is ch3, address strobe ch2 ones command
// - hardware mode: handshake pin is the receive mute on loss input
// - read strobe low drives register data; negated strobe releases bus
module hps_top #(
  parameter int DATA_W = `HPS_DATA_W,
  parameter int ADDR_W = `HPS_ADDR_W
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_host_mode,
  input wire logic [1:0] i_bus_style_select,
  input wire logic i_chip_sel_n,
  input wire logic i_addr_latch_strobe_in,
  input wire logic i_read_or_data_strobe_in,
  input wire logic i_write_or_dir_in,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_data_in,
  output logic [DATA_W-1:0] o_data_out,
  output logic o_data_oe,
  input wire logic i_access_done_n,
  output logic o_access_done_n,
  output logic o_access_done_oe,
  output logic [ADDR_W-1:0] o_reg_addr,
  output logic [DATA_W-1:0] o_reg_wdata,
  output logic o_reg_wr,
  output logic o_reg_rd,
  input wire logic [DATA_W-1:0] i_reg_rdata,
  input wire logic i_reg_ack,
  output logic o_ch2_send_ones_cmd,
  output logic o_ch3_send_ones_cmd,
  output logic o_rx_squelch_on_loss_cmd
);

  // --------------------------------------------------------------------
  // strobe decode
  // --------------------------------------------------------------------
  logic read_act;
  logic write_act;
  logic addr_load;
  logic ack_style;
  logic access_act;

  hps_strobe_decode u_dec (
    .i_bus_style_select(i_bus_style_select),
    .i_chip_sel_n(i_chip_sel_n),
    .i_addr_latch_strobe_in(i_addr_latch_strobe_in),
    .i_read_or_data_strobe_in(i_read_or_data_strobe_in),
    .i_write_or_dir_in(i_write_or_dir_in),
    .o_read_act(read_act),
    .o_write_act(write_act),
    .o_addr_load(addr_load),
    .o_ack_style(ack_style)
  );

  // host functions only in processor control mode
  assign access_act = i_host_mode && (read_act || write_act);

  // --------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------
  hps_pkg::hps_state_e state_r;
  hps_pkg::hps_state_e state_nxt;
  logic is_read_r;
  logic [ADDR_W-1:0] addr_r;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      hps_pkg::HPS_IDLE: begin
        if (access_act) begin
          state_nxt = hps_pkg::HPS_REQ;
        end
      end
      hps_pkg::HPS_REQ: begin
        state_nxt = hps_pkg::HPS_WAIT;
      end
      hps_pkg::HPS_WAIT: begin
        // completion is the only way to the done state
        if (i_reg_ack) begin
          state_nxt = hps_pkg::HPS_DONE;
        end
      end
      hps_pkg::HPS_DONE: begin
        // hold the handshake low until the processor ends the cycle
        if (!access_act) begin
          state_nxt = hps_pkg::HPS_IDLE;
        end
      end
      default: begin
        state_nxt = hps_pkg::HPS_IDLE;
      end
    endcase
    // an aborted cycle returns to idle; register side still finishes
    if (state_r != hps_pkg::HPS_IDLE && state_r != hps_pkg::HPS_WAIT &&
        !access_act) begin
      state_nxt = hps_pkg::HPS_IDLE;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      state_r <= hps_pkg::HPS_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // --------------------------------------------------------------------
  // address latch and access direction
  // --------------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      addr_r <= `HPS_ADDR_RST;
    end else if (i_host_mode && addr_load) begin
      addr_r <= i_addr;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      is_read_r <= 1'b0;
    end else if (state_r == hps_pkg::HPS_IDLE && access_act) begin
      is_read_r <= read_act;
    end
  end

  // --------------------------------------------------------------------
  // register side requests
  // --------------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_reg_addr <= `HPS_ADDR_RST;
      o_reg_wdata <= `HPS_DATA_RST;
      o_reg_wr <= 1'b0;
      o_reg_rd <= 1'b0;
    end else begin
      o_reg_wr <= 1'b0;
      o_reg_rd <= 1'b0;
      if (state_r == hps_pkg::HPS_REQ && access_act) begin
        o_reg_addr <= addr_r;
        o_reg_wdata <= i_data_in;
        o_reg_rd <= is_read_r;
        o_reg_wr <= !is_read_r;
      end
    end
  end

  // --------------------------------------------------------------------
  // read data bus
  // --------------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_data_out <= `HPS_DATA_RST;
    end else if (state_r == hps_pkg::HPS_WAIT && i_reg_ack && is_read_r) begin
      o_data_out <= i_reg_rdata;
    end
  end

  // driven only while the read strobe is held with chip select low
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_data_oe <= 1'b0;
    end else begin
      o_data_oe <= i_host_mode && read_act;
    end
  end

  // --------------------------------------------------------------------
  // ready / acknowledge pin
  // --------------------------------------------------------------------
  // low only in the done state, high while the cycle is stretched
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_access_done_n <= 1'b1;
    end else begin
      // an aborted cycle that completes late must not pulse the pin low
      o_access_done_n <= !(state_nxt == hps_pkg::HPS_DONE &&
        access_act);
    end
  end

  // ready style drives the pin whenever selected; ack style only in a cycle
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_access_done_oe <= 1'b0;
    end else if (!i_host_mode || i_chip_sel_n) begin
      o_access_done_oe <= 1'b0;
    end else if (ack_style) begin
      o_access_done_oe <= access_act;
    end else begin
      o_access_done_oe <= 1'b1;
    end
  end

  // --------------------------------------------------------------------
  // hardware mode commands
  // --------------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_ch2_send_ones_cmd <= 1'b0;
      o_ch3_send_ones_cmd <= 1'b0;
      o_rx_squelch_on_loss_cmd <= 1'b0;
    end else if (!i_host_mode) begin
      o_ch3_send_ones_cmd <= i_chip_sel_n;
      o_ch2_send_ones_cmd <= i_addr_latch_strobe_in;
      o_rx_squelch_on_loss_cmd <= i_access_done_n;
    end else begin
      o_ch2_send_ones_cmd <= 1'b0;
      o_ch3_send_ones_cmd <= 1'b0;
      o_rx_squelch_on_loss_cmd <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// *** hps_defines.svh ***
// constants for the host port select and ready handshake block
`ifndef HPS_DEFINES_SVH
`define HPS_DEFINES_SVH

// ----------------------------------------------------------------------
// bus style select codes
// ----------------------------------------------------------------------
`define HPS_STYLE_W 2
`define HPS_STYLE_RDY 2'h0
`define HPS_STYLE_ACK 2'h1

// ----------------------------------------------------------------------
// widths and reset values
// ----------------------------------------------------------------------
`define HPS_DATA_W 8
`define HPS_ADDR_W 8
`define HPS_DATA_RST 8'h00
`define HPS_ADDR_RST 8'h00

`endif

// *** hps_pkg.sv ***
// types for the host port select and ready handshake block
package hps_pkg;

  // --------------------------------------------------------------------
  // handshake state machine
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    HPS_IDLE = 2'b00,
    HPS_REQ = 2'b01,
    HPS_WAIT = 2'b10,
    HPS_DONE = 2'b11
  } hps_state_e;

endpackage

// *** hps_strobe_decode.sv ***
// per-style decode of the host port strobes
`timescale 1ns/1ns
`default_nettype none
`include "hps_defines.svh"

module hps_strobe_decode (
  input wire logic [1:0] i_bus_style_select,
  input wire logic i_chip_sel_n,
  input wire logic i_addr_latch_strobe_in,
  input wire logic i_read_or_data_strobe_in,
  input wire logic i_write_or_dir_in,
  output logic o_read_act,
  output logic o_write_act,
  output logic o_addr_load,
  output logic o_ack_style
);

  // --------------------------------------------------------------------
  // strobe decode
  // --------------------------------------------------------------------
  // ready style: separate read and write strobes, address latch high
  // ack style: one data strobe plus direction, address strobe low
  always_comb begin
    o_ack_style = (i_bus_style_select == `HPS_STYLE_ACK);
    o_read_act = 1'b0;
    o_write_act = 1'b0;
    o_addr_load = 1'b0;
    if (!i_chip_sel_n) begin
      if (o_ack_style) begin
        o_read_act = !i_read_or_data_strobe_in && i_write_or_dir_in;
        o_write_act = !i_read_or_data_strobe_in && !i_write_or_dir_in;
        o_addr_load = !i_addr_latch_strobe_in;
      end else begin
        o_read_act = !i_read_or_data_strobe_in;
        o_write_act = !i_write_or_dir_in && i_read_or_data_strobe_in;
        o_addr_load = i_addr_latch_strobe_in;
      end
    end
  end

endmodule
`default_nettype wire

// *** hps_top_sva.sv ***
// port assertions for the host port handshake block
`timescale 1ns/1ns
`default_nettype none
`include "hps_defines.svh"
module hps_top_sva (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_host_mode,
  input wire logic [1:0] i_bus_style_select,
  input wire logic i_chip_sel_n,
  input wire logic i_addr_latch_strobe_in,
  input wire logic i_read_or_data_strobe_in,
  input wire logic i_access_done_n,
  input wire logic i_reg_ack,
  input wire logic o_data_oe,
  input wire logic o_access_done_n,
  input wire logic o_access_done_oe,
  input wire logic o_reg_wr,
  input wire logic o_reg_rd,
  input wire logic o_ch2_send_ones_cmd,
  input wire logic o_ch3_send_ones_cmd,
  input wire logic o_rx_squelch_on_loss_cmd
);
  // ------------------------------------------------------------------
  // port relations
  // ------------------------------------------------------------------
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  logic ack_st;
  assign ack_st = i_bus_style_select == `HPS_STYLE_ACK;
  chk_hw_ones_copy: assert property (
    !i_host_mode && !$past(i_host_mode) && $past(i_rst_n) |->
    o_ch2_send_ones_cmd == $past(i_addr_latch_strobe_in) &&
    o_ch3_send_ones_cmd == $past(i_chip_sel_n))
    else $error("ones command copy wrong");
  chk_hw_squelch_copy: assert property (
    !i_host_mode && !$past(i_host_mode) && $past(i_rst_n) |->
    o_rx_squelch_on_loss_cmd == $past(i_access_done_n))
    else $error("squelch command copy wrong");
  chk_hw_pin_free: assert property (
    !i_host_mode && !$past(i_host_mode) |-> !o_access_done_oe)
    else $error("handshake pin driven in pin mode");
  chk_host_cmds_off: assert property (
    i_host_mode && $past(i_host_mode) |-> !o_ch2_send_ones_cmd &&
    !o_ch3_send_ones_cmd && !o_rx_squelch_on_loss_cmd)
    else $error("pin commands active in host mode");
  chk_ready_after_ack: assert property (
    $fell(o_access_done_n) |-> $past(i_reg_ack))
    else $error("handshake low before register answer");
  chk_ready_drive: assert property (
    i_host_mode && !ack_st && !i_chip_sel_n |=> o_access_done_oe)
    else $error("ready not driven while selected");
  chk_read_drive: assert property (
    i_host_mode && !ack_st |=> o_data_oe ==
    !($past(i_chip_sel_n) || $past(i_read_or_data_strobe_in)))
    else $error("data bus drive wrong");
  chk_cs_quiet: assert property (
    i_chip_sel_n && $past(i_chip_sel_n) && $past(i_chip_sel_n, 2)
    |-> !o_reg_rd && !o_reg_wr && !o_data_oe)
    else $error("activity while deselected");
  chk_ack_drive: assert property (
    ack_st && !o_access_done_n |-> o_access_done_oe)
    else $error("acknowledge low but not driven");
endmodule
`default_nettype wire

// *** hps_host_model.sv ***
// processor bus master model for the host port
`timescale 1ns/1ns
`default_nettype none
module hps_host_model (
  input wire logic i_ref_clk,
  input wire logic i_done_n,
  output logic o_cs_n,
  output logic o_ale,
  output logic o_strobe_n,
  output logic o_dir
);
  // ------------------------------------------------------------------
  // one access per call
  // ------------------------------------------------------------------
  initial begin
    o_cs_n = 1'h1;
    o_ale = 1'h0;
    o_strobe_n = 1'h1;
    o_dir = 1'h1;
  end
  task automatic access(input logic rd, input logic ack, output logic ok);
    int n;
    @(posedge i_ref_clk);
    #1;
    o_cs_n = 1'h0;
    o_ale = !ack;
    o_dir = rd;
    o_strobe_n = ack ? 1'h0 : !rd;
    n = 0;
    do begin
      @(posedge i_ref_clk);
      n++;
    end while ((n < 3 || i_done_n) && n < 60);
    ok = !i_done_n;
    #1;
    o_cs_n = 1'h1;
    o_strobe_n = 1'h1;
    o_dir = 1'h1;
    o_ale = ack;
    repeat (2) @(posedge i_ref_clk);
    #1;
  endtask
endmodule
`default_nettype wire

// *** hps_top_tb.sv ***
// self-checking testbench for the host port handshake block
`timescale 1ns/1ns
`default_nettype none
`include "hps_defines.svh"
module hps_top_tb;
  // ------------------------------------------------------------------
  // pins, register side and checks
  // ------------------------------------------------------------------
  logic clk = 1'h0, rst_n = 1'h0, host = 1'h1, tbdrv = 1'h0, rack = 1'h0;
  logic [1:0] style = 2'h0;
  logic [4:0] hw = 5'h00;
  logic [7:0] addr = 8'h00, wdat = 8'h00, rdat = 8'h00;
  logic m_cs, m_ale, m_str, m_dir, pin, oe, done_n, d_oe, rrd, rwr;
  logic c2, c3, cmute;
  logic [7:0] dout, raddr, rwd, wr_a, wr_d;
  logic [3:0] lat = 4'h0;
  logic [31:0] seed = 32'hF01722E3;
  int reqs = 0, mismatches = 0, comparisons = 0, cycles = 0;
  always #5 clk = ~clk;
  assign pin = oe ? done_n : (host ? 1'h0 : hw[4]);
  hps_top hps_top_i (.i_ref_clk(clk), .i_rst_n(rst_n), .i_host_mode(host),
    .i_bus_style_select(style), .i_chip_sel_n(tbdrv ? hw[0] : m_cs),
    .i_addr_latch_strobe_in(tbdrv ? hw[1] : m_ale),
    .i_read_or_data_strobe_in(tbdrv ? hw[2] : m_str),
    .i_write_or_dir_in(tbdrv ? hw[3] : m_dir), .i_addr(addr),
    .i_data_in(wdat), .o_data_out(dout), .o_data_oe(d_oe),
    .i_access_done_n(pin), .o_access_done_n(done_n),
    .o_access_done_oe(oe), .o_reg_addr(raddr), .o_reg_wdata(rwd),
    .o_reg_wr(rwr), .o_reg_rd(rrd), .i_reg_rdata(rack ? rdat : ~rdat),
    .i_reg_ack(rack), .o_ch2_send_ones_cmd(c2),
    .o_ch3_send_ones_cmd(c3), .o_rx_squelch_on_loss_cmd(cmute));
  hps_host_model hps_host_model_i (.i_ref_clk(clk), .i_done_n(pin),
    .o_cs_n(m_cs), .o_ale(m_ale), .o_strobe_n(m_str), .o_dir(m_dir));
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    return a ^ 8'h5A;
  endfunction
  always @(posedge clk) begin
    rack <= 1'h0;
    if (rrd || rwr) begin
      lat <= {1'h0, seed[2:0]} + 4'h1;
      reqs <= reqs + 1;
      rdat <= exp_rd(raddr);
      if (rwr) begin
        wr_a <= raddr;
        wr_d <= rwd;
      end
    end else if (lat != 4'h0) begin
      lat <= lat - 4'h1;
      rack <= lat == 4'h1;
    end
  end
  task automatic chk(input string what, input logic [7:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic run_one(input logic rd, input logic [7:0] a, d);
    logic ok;
    @(posedge clk);
    #1;
    addr = a;
    wdat = d;
    hps_host_model_i.access(rd, style == `HPS_STYLE_ACK, ok);
    chk("handshake", 8'h01, {7'h00, ok});
    if (rd) chk("read data", exp_rd(a), dout);
    if (!rd) chk("write addr", a, wr_a);
    if (!rd) chk("write data", d, wr_d);
  endtask
  task automatic drive_pins(input logic hmode);
    int r0;
    r0 = reqs;
    tbdrv = 1'h1;
    host = hmode;
    repeat (24) begin
      seed = nxt(seed);
      hw = seed[4:0] | {4'h0, hmode};
      @(posedge clk);
      #1;
      if (!hmode) begin
        chk("pin cmds", {5'h00, hw[4], hw[1:0]},
          {5'h00, cmute, c2, c3});
      end
    end
    repeat (3) @(posedge clk);
    #1;
    chk("stray requests", 8'h00, 8'(reqs - r0));
    tbdrv = 1'h0;
    host = 1'h1;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      mismatches++;
      complete_run;
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    #1;
    rst_n = 1'h1;
    for (int s = 0; s < 4; s++) begin
      style = s[1:0];
      repeat (8) begin
        seed = nxt(seed);
        run_one(seed[16], seed[7:0], seed[15:8]);
      end
      run_one(1'h1, 8'hFF, 8'h00);
      run_one(1'h0, 8'h00, 8'hFF);
      $display("style %0d test done", s);
    end
    drive_pins(1'h0);
    $display("pin mode test done");
    drive_pins(1'h1);
    $display("deselected test done");
    complete_run;
  end
endmodule
bind hps_top hps_top_sva hps_top_sva_i (.i_ref_clk(i_ref_clk),
  .i_rst_n(i_rst_n), .i_host_mode(i_host_mode),
  .i_bus_style_select(i_bus_style_select), .i_chip_sel_n(i_chip_sel_n),
  .i_addr_latch_strobe_in(i_addr_latch_strobe_in),
  .i_read_or_data_strobe_in(i_read_or_data_strobe_in),
  .i_access_done_n(i_access_done_n), .i_reg_ack(i_reg_ack),
  .o_data_oe(o_data_oe), .o_access_done_n(o_access_done_n),
  .o_access_done_oe(o_access_done_oe), .o_reg_wr(o_reg_wr),
  .o_reg_rd(o_reg_rd), .o_ch2_send_ones_cmd(o_ch2_send_ones_cmd),
  .o_ch3_send_ones_cmd(o_ch3_send_ones_cmd),
  .o_rx_squelch_on_loss_cmd(o_rx_squelch_on_loss_cmd));
`default_nettype wire
